/* File: shared/rx_payload_consts.svh */
// Named constants for the receive payload conditioning block.
// Assumes inclusion by bare name from the shared folder on the include path.
`ifndef RX_PAYLOAD_CONSTS_SVH
`define RX_PAYLOAD_CONSTS_SVH

// ----------------------------------------------------------------------------
// Direct register offsets within one link window
// ----------------------------------------------------------------------------
`define OFF_PAYLOAD_TEST_CFG   8'hC7
`define OFF_INDIRECT_STATUS    8'hCD
`define OFF_INDIRECT_CONTROL   8'hCE
`define OFF_INDIRECT_DATA      8'hCF
`define OFF_PAYLOAD_GLOBAL_CFG 8'hD0
`define OFF_PAYLOAD_CTRL_EN    8'hD1
`define LINK_COUNT             4
`define LINK_SEL_MSB           9
`define LINK_SEL_LSB           8

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CTL_ADDR_MSB           6
`define CTL_RWN_BIT            7
`define STATUS_BUSY_BIT        0
`define GCFG_SUBST_MSB         2
`define GCFG_SNAP_BIT          3
`define GCFG_GSTRK_BIT         4
`define CEN_MASTER_BIT         0
`define CEN_FIX_BIT            1
`define CEN_LEVEL_BIT          2
`define CEN_NIBBLE_BIT         3
`define CHC_SUBST_MSB          2
`define CHC_EVEN_BITS_INVERT_BIT           3
`define CHC_ODD_BITS_INVERT_BIT           4
`define CHC_SIGN_BIT_INVERT_BIT           5
`define STC_CHANNEL_SIGNALING_TRUNK_ENABLE_BIT         4

// ----------------------------------------------------------------------------
// Indirect index bases and substitution codes
// ----------------------------------------------------------------------------
`define IDX_CHAN_CONTROL       2'h0
`define IDX_DATA_TRUNK         2'h1
`define IDX_SIG_TRUNK          2'h2
`define SUBST_NONE             3'h0
`define SUBST_DATA_TRUNK       3'h1
`define SUBST_MW_MU            3'h2
`define SUBST_MW_A             3'h3
`define MASK_SIGN              8'h80
`define MASK_ODD               8'hAA
`define MASK_EVEN              8'h55
`define INDIRECT_BUSY_CYCLES   2'h2
`define RESET_BYTE             8'h00

`endif

/* File: shared/rx_payload_pkg.sv */
// Types shared by the receive payload conditioning block.
// Assumes nothing beyond a SystemVerilog compiler.
package rx_payload_pkg;

  // Framing mode of one link, steady while traffic runs.
  typedef struct packed {
    logic e1;
    logic t1_dm;
    logic esf_slc;
  } link_mode_t;

  // One received channel byte with its signaling nibble.
  typedef struct packed {
    logic       valid;
    logic [4:0] chan;
    logic       mf_start;
    logic [7:0] data;
    logic [3:0] sig;
  } stream_in_t;

  // One conditioned channel byte towards the backplane.
  typedef struct packed {
    logic       valid;
    logic [4:0] chan;
    logic [7:0] data;
    logic [7:0] sig;
  } stream_out_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b100
  } access_state_t;

endpackage

/* File: rtl/indirect_store.sv */
// Indirect register store of one link with its access sequencer.
// Assumes host strobes are single-cycle and synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "rx_payload_consts.svh"

module indirect_store
  import rx_payload_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // Host side
  input  wire logic       ctl_we,
  input  wire logic       data_we,
  input  wire logic [7:0] wdata,
  output logic      [7:0] data_q,
  output logic            busy,
  // Datapath lookups
  input  wire logic [6:0] rd_idx_a,
  input  wire logic [6:0] rd_idx_b,
  input  wire logic [6:0] rd_idx_c,
  output logic      [7:0] rd_val_a,
  output logic      [7:0] rd_val_b,
  output logic      [7:0] rd_val_c
);

  logic [7:0]    mem [128];
  access_state_t state;
  logic [6:0]    idx;
  logic          indirect_read_write_select;
  logic [1:0]    wait_cnt;

  assign rd_val_a = mem[rd_idx_a];
  assign rd_val_b = mem[rd_idx_b];
  assign rd_val_c = mem[rd_idx_c];
  assign busy     = (state != ST_IDLE);

  // --------------------------------------------------------------------------
  // Access sequencer
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      state    <= ST_IDLE;
      idx      <= 7'h00;
      indirect_read_write_select      <= 1'b0;
      wait_cnt <= 2'h0;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          if (ctl_we)
          begin
            idx      <= wdata[`CTL_ADDR_MSB:0];
            indirect_read_write_select      <= wdata[`CTL_RWN_BIT];
            wait_cnt <= `INDIRECT_BUSY_CYCLES;
            state    <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          wait_cnt <= wait_cnt - 2'h1;
          if (wait_cnt == 2'h1)
          begin
            state <= ST_DONE;
          end
        end
        ST_DONE:
        begin
          state <= ST_IDLE;
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Data register and storage
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      data_q <= `RESET_BYTE;
    end
    else if (state == ST_DONE && indirect_read_write_select)
    begin
      data_q <= mem[idx];
    end
    else if (data_we && !busy)
    begin
      data_q <= wdata;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (state == ST_DONE && !indirect_read_write_select)
    begin
      mem[idx] <= data_q;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/signaling_conditioner.sv */
// Signaling snapshot, trunk replacement and nibble placement of one link.
// Assumes one input byte per channel per frame with mf_start on the first frame.
`timescale 1ns/1ps
`default_nettype none
`include "rx_payload_consts.svh"

module signaling_conditioner
  import rx_payload_pkg::*;
(
  // Clock
  input  wire logic       sys_clk,
  // Stream
  input  wire stream_in_t rx,
  input  wire link_mode_t mode,
  // Controls
  input  wire logic       master_en,
  input  wire logic       snap_en,
  input  wire logic       trunk_en,
  input  wire logic [3:0] trunk_code,
  input  wire logic       nibble_pos,
  input  wire logic       fix_en,
  input  wire logic       fix_level,
  // Result
  output logic      [7:0] sig_byte
);

  logic [3:0] snap_mem [32];
  logic [3:0] held;
  logic [3:0] chosen;
  logic       snap_on;

  always_ff @(posedge sys_clk)
  begin
    if (rx.valid && rx.mf_start)
    begin
      snap_mem[rx.chan] <= rx.sig;
    end
  end

  assign snap_on = master_en && snap_en && !mode.t1_dm;

  always_comb
  begin
    held = (snap_on && !rx.mf_start) ? snap_mem[rx.chan] : rx.sig;
    chosen = held;
    if (master_en && trunk_en)
    begin
      chosen = trunk_code;
    end
    if (master_en && fix_en && !mode.e1 && !mode.t1_dm)
    begin
      chosen = {4{fix_level}};
    end
    sig_byte = {4'h0, chosen};
    if (master_en && nibble_pos && !mode.e1 && mode.esf_slc)
    begin
      sig_byte = {4'h0, chosen[3:2], 2'h0};
    end
  end

endmodule
`default_nettype wire

/* File: rtl/rx_payload_control.sv */
// Four-link receive payload conditioning with direct and indirect registers.
// Assumes a synchronous byte-wide host port and one byte per channel per frame.
`timescale 1ns/1ps
`default_nettype none
`include "rx_payload_consts.svh"

// Behaviour
// - Mu-law milliwatt outputs fixed eight-byte sequence
// - Signaling priority: nibble, fixed level, trunk replacement, snapshot
// - Nibble select places signaling in chosen positions
// - Nibble select only in T1 ESF/SLC-96
// - Snapshot holds first-frame signaling whole multiframe
// - Global trunk enable replaces every channel's ABCD
// - Otherwise per-channel trunk enable selects replacement
// - Indirect access by index, direction, data, busy
// - Signaling trunk entries at indices 40h onward
// - Data trunk and channel control index ranges
// - Master enable gates all conditioning functions
// - Global select zero defers to channel select
module rx_payload_control
  import rx_payload_pkg::*;
(
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  srst,
  // Host register port
  input  wire logic                  reg_cs,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [9:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  output logic      [7:0]            reg_rdata,
  // Links
  input  wire link_mode_t [3:0]      link_mode,
  input  wire stream_in_t [3:0]      rx_in,
  output stream_out_t     [3:0]      rx_out
);

  logic [7:0] rd_val [`LINK_COUNT];
  logic [1:0] link_sel;

  assign link_sel = reg_addr[`LINK_SEL_MSB:`LINK_SEL_LSB];

  // --------------------------------------------------------------------------
  // Host read data
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      reg_rdata <= `RESET_BYTE;
    end
    else if (reg_cs && reg_rd)
    begin
      reg_rdata <= rd_val[link_sel];
    end
  end

  // --------------------------------------------------------------------------
  // Per-link logic
  // --------------------------------------------------------------------------
  for (genvar l = 0; l < `LINK_COUNT; l++)
  begin : g_link
    logic [7:0] test_cfg;
    logic [7:0] global_cfg;
    logic [7:0] ctrl_en;
    logic       sel_hit;
    logic       wr_ctl;
    logic       wr_data;
    logic [7:0] ind_data;
    logic       ind_busy;
    logic [7:0] chan_ctl;
    logic [7:0] data_trunk;
    logic [7:0] sig_trunk;
    logic [7:0] sig_byte;
    logic [2:0] subst;
    logic [2:0] mw_idx [32];
    logic [7:0] next_data;
    logic       mw_used;
    logic       master_en;
    stream_in_t rx;

    assign rx        = rx_in[l];
    assign sel_hit   = reg_cs && reg_wr && (link_sel == 2'(l));
    assign wr_ctl    = sel_hit && (reg_addr[7:0] == `OFF_INDIRECT_CONTROL);
    assign wr_data   = sel_hit && (reg_addr[7:0] == `OFF_INDIRECT_DATA);
    assign master_en = ctrl_en[`CEN_MASTER_BIT];

    // Direct registers; control writes while busy are dropped by the store.
    always_ff @(posedge sys_clk)
    begin
      if (srst)
      begin
        test_cfg   <= `RESET_BYTE;
        global_cfg <= `RESET_BYTE;
        ctrl_en    <= `RESET_BYTE;
      end
      else if (sel_hit)
      begin
        if (reg_addr[7:0] == `OFF_PAYLOAD_TEST_CFG)
        begin
          test_cfg <= reg_wdata;
        end
        if (reg_addr[7:0] == `OFF_PAYLOAD_GLOBAL_CFG)
        begin
          global_cfg <= reg_wdata;
        end
        if (reg_addr[7:0] == `OFF_PAYLOAD_CTRL_EN)
        begin
          ctrl_en <= reg_wdata;
        end
      end
    end

    always_comb
    begin
      unique case (reg_addr[7:0])
        `OFF_PAYLOAD_TEST_CFG:   rd_val[l] = test_cfg;
        `OFF_INDIRECT_STATUS:    rd_val[l] = {7'h00, ind_busy};
        `OFF_INDIRECT_CONTROL:   rd_val[l] = `RESET_BYTE;
        `OFF_INDIRECT_DATA:      rd_val[l] = ind_data;
        `OFF_PAYLOAD_GLOBAL_CFG: rd_val[l] = global_cfg;
        `OFF_PAYLOAD_CTRL_EN:    rd_val[l] = ctrl_en;
        default:                 rd_val[l] = `RESET_BYTE;
      endcase
    end

    indirect_store u_store (
      .sys_clk  (sys_clk),
      .srst     (srst),
      .ctl_we   (wr_ctl),
      .data_we  (wr_data),
      .wdata    (reg_wdata),
      .data_q   (ind_data),
      .busy     (ind_busy),
      .rd_idx_a ({`IDX_CHAN_CONTROL, rx.chan}),
      .rd_idx_b ({`IDX_DATA_TRUNK, rx.chan}),
      .rd_idx_c ({`IDX_SIG_TRUNK, rx.chan}),
      .rd_val_a (chan_ctl),
      .rd_val_b (data_trunk),
      .rd_val_c (sig_trunk)
    );

    signaling_conditioner u_sig (
      .sys_clk    (sys_clk),
      .rx         (rx),
      .mode       (link_mode[l]),
      .master_en  (master_en),
      .snap_en    (global_cfg[`GCFG_SNAP_BIT]),
      .trunk_en   (global_cfg[`GCFG_GSTRK_BIT] || sig_trunk[`STC_CHANNEL_SIGNALING_TRUNK_ENABLE_BIT]),
      .trunk_code (sig_trunk[3:0]),
      .nibble_pos (ctrl_en[`CEN_NIBBLE_BIT]),
      .fix_en     (ctrl_en[`CEN_FIX_BIT]),
      .fix_level  (ctrl_en[`CEN_LEVEL_BIT]),
      .sig_byte   (sig_byte)
    );

    // Data substitution, then inversions.
    always_comb
    begin
      subst = (global_cfg[`GCFG_SUBST_MSB:0] != `SUBST_NONE) ?
              global_cfg[`GCFG_SUBST_MSB:0] : chan_ctl[`CHC_SUBST_MSB:0];
      next_data = rx.data;
      mw_used   = 1'b0;
      if (master_en)
      begin
        unique case (subst)
          `SUBST_DATA_TRUNK: next_data = data_trunk;
          `SUBST_MW_MU:
          begin
            mw_used = 1'b1;
            unique case (mw_idx[rx.chan])
              3'h0, 3'h3: next_data = 8'h1E;
              3'h1, 3'h2: next_data = 8'h0B;
              3'h4, 3'h7: next_data = 8'h9E;
              3'h5, 3'h6: next_data = 8'h8B;
            endcase
          end
          `SUBST_MW_A:
          begin
            mw_used = 1'b1;
            unique case (mw_idx[rx.chan])
              3'h0, 3'h3: next_data = 8'h34;
              3'h1, 3'h2: next_data = 8'h21;
              3'h4, 3'h7: next_data = 8'hB4;
              3'h5, 3'h6: next_data = 8'hA1;
            endcase
          end
          default: next_data = rx.data;
        endcase
        if (chan_ctl[`CHC_SIGN_BIT_INVERT_BIT])
        begin
          next_data = next_data ^ `MASK_SIGN;
        end
        if (chan_ctl[`CHC_ODD_BITS_INVERT_BIT])
        begin
          next_data = next_data ^ `MASK_ODD;
        end
        if (chan_ctl[`CHC_EVEN_BITS_INVERT_BIT])
        begin
          next_data = next_data ^ `MASK_EVEN;
        end
      end
    end

    // Milliwatt byte index per channel; the 3-bit count wraps 7 to 0.
    always_ff @(posedge sys_clk)
    begin
      if (srst)
      begin
        for (int c = 0; c < 32; c++)
        begin
          mw_idx[c] <= 3'h0;
        end
      end
      else if (rx.valid && mw_used)
      begin
        mw_idx[rx.chan] <= mw_idx[rx.chan] + 3'h1;
      end
    end

    always_ff @(posedge sys_clk)
    begin
      if (srst)
      begin
        rx_out[l] <= '0;
      end
      else
      begin
        rx_out[l].valid <= rx.valid;
        rx_out[l].chan  <= rx.chan;
        rx_out[l].data  <= next_data;
        rx_out[l].sig   <= sig_byte;
      end
    end
  end

endmodule
`default_nettype wire

/* File: tb/rx_payload_chk.sv */
// Port assertions for the four-link receive payload block.
// Assumes binding to rx_payload_control; link 0 carries the traffic.
`timescale 1ns/1ps
`default_nettype none

module rx_payload_chk
  import rx_payload_pkg::*;
(
  // Clock and reset
  input wire logic                  sys_clk,
  input wire logic                  srst,
  // Host register port
  input wire logic                  reg_cs,
  input wire logic                  reg_wr,
  input wire logic                  reg_rd,
  input wire logic        [9:0]     reg_addr,
  input wire logic        [7:0]     reg_wdata,
  input wire logic        [7:0]     reg_rdata,
  // Links
  input wire link_mode_t  [3:0]     link_mode,
  input wire stream_in_t  [3:0]     rx_in,
  input wire stream_out_t [3:0]     rx_out
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic m_en;

  // Shadow of the link 0 master enable.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      m_en <= 1'b0;
    else if (reg_cs && reg_wr && reg_addr == 10'h0D1)
      m_en <= reg_wdata[0];
  end

  sequence s_ctl_wr;
    reg_cs && reg_wr && reg_addr[7:0] == 8'hCE;
  endsequence
  sequence s_st_rd;
    reg_cs && reg_rd && reg_addr[7:0] == 8'hCD;
  endsequence

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  AST_OUT_VALID: assert property (rx_in[0].valid |=> rx_out[0].valid)
    else $error("output byte missing");
  AST_OUT_CHAN: assert property (rx_in[0].valid |=> rx_out[0].chan == $past(rx_in[0].chan))
    else $error("output channel wrong");
  AST_IDLE: assert property (!rx_in[0].valid |=> !rx_out[0].valid)
    else $error("spurious output byte");
  AST_UNMAPPED: assert property (reg_cs && reg_rd && reg_addr[7:0] == 8'h10 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_CTL_ZERO: assert property (reg_cs && reg_rd && reg_addr[7:0] == 8'hCE |=> reg_rdata == 8'h00)
    else $error("control read not zero");
  AST_BUSY_SET: assert property (s_ctl_wr ##[1:2] s_st_rd |=> reg_rdata[0])
    else $error("busy not set");
  AST_BUSY_CLR: assert property (s_ctl_wr ##1 (!(reg_cs && reg_wr && reg_addr[7:0] == 8'hCE))[*3] ##[1:4] s_st_rd |=> !reg_rdata[0])
    else $error("busy not cleared");
  AST_PASS: assert property (!m_en && rx_in[0].valid |=> rx_out[0].data == $past(rx_in[0].data) && rx_out[0].sig == {4'h0, $past(rx_in[0].sig)})
    else $error("pass-through broken");
  AST_SIG_UPPER: assert property (rx_in[0].valid |=> rx_out[0].sig[7:4] == 4'h0)
    else $error("signaling upper bits set");

  // The other links carry their own stream one cycle later.
  for (genvar n = 1; n < 4; n++)
  begin : g_follow
    AST_LINK_FOLLOW: assert property (
      {rx_out[n].valid, rx_out[n].chan} == $past({rx_in[n].valid, rx_in[n].chan}))
      else $error("link output does not follow its input");
  end
endmodule

bind rx_payload_control rx_payload_chk i_rx_payload_chk (
  .sys_clk   (sys_clk),
  .srst      (srst),
  .reg_cs    (reg_cs),
  .reg_wr    (reg_wr),
  .reg_rd    (reg_rd),
  .reg_addr  (reg_addr),
  .reg_wdata (reg_wdata),
  .reg_rdata (reg_rdata),
  .link_mode (link_mode),
  .rx_in     (rx_in),
  .rx_out    (rx_out)
);

`default_nettype wire

/* File: tb/backplane_sink.sv */
// Backplane side: takes every conditioned byte of one link.
// Assumes no backpressure, as the block offers none.
`timescale 1ns/1ps
`default_nettype none

module backplane_sink
  import rx_payload_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // Conditioned stream
  input  wire stream_out_t rx_out,
  output var  int          bytes_seen
);
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      bytes_seen <= 0;
    else if (rx_out.valid)
      bytes_seen <= bytes_seen + 1;
  end
endmodule

`default_nettype wire

/* File: tb/receive_payload_signaling_control_tb_top.sv */
// Self-checking bench for the receive payload block.
// Assumes the bound checker and the backplane sink model.
`timescale 1ns/1ps
`default_nettype none

module receive_payload_signaling_control_tb_top;
  import rx_payload_pkg::*;
  logic                 sys_clk, srst, reg_cs, reg_wr, reg_rd;
  logic        [9:0]    reg_addr;
  logic        [7:0]    reg_wdata, reg_rdata, v, d0, d1;
  link_mode_t  [3:0]    link_mode;
  stream_in_t  [3:0]    rx_in;
  stream_out_t [3:0]    rx_out;
  int                   fail_count, num_checks, seen, sent;
  logic        [7:0]    mem [4][128];
  logic        [7:0]    rv [13];
  logic        [3:0]    snap [32];
  int                   mw [32];
  stream_out_t          pend [$];
  logic        [7:0]    pm [$];
  logic        [7:0]    mu [8] = '{8'h1E, 8'h0B, 8'h0B, 8'h1E, 8'h9E, 8'h8B, 8'h8B, 8'h9E};
  logic        [7:0]    al [8] = '{8'h34, 8'h21, 8'h21, 8'h34, 8'hB4, 8'hA1, 8'hA1, 8'hB4};
  logic        [7:0]    offs [3] = '{8'hC7, 8'hD0, 8'hD1};
  logic        [6:0]    idx [13] = '{7'h01, 7'h18, 7'h21, 7'h38, 7'h41, 7'h58, 7'h00,
                                     7'h1F, 7'h20, 7'h3F, 7'h4F, 7'h51, 7'h5F};
  logic        [2:0]    ph_mode [7] = '{3'b100, 3'b100, 3'b100, 3'b001, 3'b001, 3'b010, 3'b100};
  logic        [7:0]    ph_d0 [7] = '{8'h08, 8'h12, 8'h03, 8'h00, 8'h0C, 8'h08, 8'h12};
  logic        [7:0]    ph_d1 [7] = '{8'h01, 8'h09, 8'h01, 8'h0F, 8'h09, 8'h0F, 8'h00};

  rx_payload_control i_rx_payload_control (.sys_clk(sys_clk), .srst(srst), .reg_cs(reg_cs),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .link_mode(link_mode), .rx_in(rx_in), .rx_out(rx_out));
  backplane_sink i_backplane_sink (.sys_clk(sys_clk), .srst(srst), .rx_out(rx_out[0]),
    .bytes_seen(seen));

  // ---------------------------------------------------------------
  // Tasks and model
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    {reg_cs, reg_wr, reg_addr, reg_wdata} = {2'b11, a, d};
    @(negedge sys_clk);
    {reg_cs, reg_wr} = 2'b00;
  endtask

  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    {reg_cs, reg_rd, reg_addr} = {2'b11, a};
    @(negedge sys_clk);
    {reg_cs, reg_rd} = 2'b00;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask

  // Indirect access; the host waits on busy before anything else.
  task automatic iw(input logic [1:0] l, input logic [6:0] i, input logic [7:0] d,
      input logic indirect_read_write_select);
    int n;
    n = 0;
    if (!indirect_read_write_select)
      wr({l, 8'hCF}, d);
    wr({l, 8'hCE}, {indirect_read_write_select, i});
    rd({l, 8'hCD}, v);
    chk(v[0], 1'b1, "busy");
    while (v[0] !== 1'b0 && n < 20)
    begin
      rd({l, 8'hCD}, v);
      n++;
    end
    chk(v[0], 1'b0, "busy clear");
    if (!indirect_read_write_select)
      mem[l][i] = d;
  endtask

  function automatic stream_out_t model(input logic [4:0] c, input logic mf,
      input logic [7:0] d, input logic [3:0] s);
    link_mode_t m;
    logic [7:0] ct, dd, st;
    logic [3:0] sv;
    logic [2:0] sb;
    if (!d1[0])
      return '{1'b1, c, d, {4'h0, s}};
    m = link_mode[0];
    ct = mem[0][{2'h0, c}];
    st = mem[0][{2'h2, c}];
    sb = d0[2:0] != 3'h0 ? d0[2:0] : ct[2:0];
    dd = sb == 3'h1 ? mem[0][{2'h1, c}] : d;
    sv = s;
    if (sb == 3'h2 || sb == 3'h3)
    begin
      dd = sb == 3'h2 ? mu[mw[c]] : al[mw[c]];
      mw[c] = (mw[c] + 1) % 8;
    end
    dd = dd ^ (ct[3] ? 8'h55 : 8'h00) ^ (ct[4] ? 8'hAA : 8'h00) ^ (ct[5] ? 8'h80 : 8'h00);
    if (d0[3] && !m.t1_dm)
    begin
      if (mf)
        snap[c] = s;
      sv = snap[c];
    end
    if (d0[4] || st[4])
      sv = st[3:0];
    if (d1[1] && !m.e1 && !m.t1_dm)
      sv = {4{d1[2]}};
    if (d1[3] && !m.e1 && m.esf_slc)
      sv = {sv[3:2], 2'b00};
    return '{1'b1, c, dd, {4'h0, sv}};
  endfunction

  task automatic check_out;
    stream_out_t e;
    logic [7:0] mk;
    if (pend.size() > 0)
    begin
      e = pend.pop_front();
      mk = pm.pop_front();
      chk({rx_out[0].valid, rx_out[0].chan, rx_out[0].data, rx_out[0].sig & mk}, e, "byte");
    end
  endtask

  task automatic send(input logic [4:0] c, input logic mf);
    logic [7:0] d;
    logic [3:0] s;
    d = 8'($urandom);
    s = 4'($urandom);
    @(negedge sys_clk);
    check_out();
    rx_in[0] = '{1'b1, c, mf, d, s};
    rx_in[3:1] = 57'({$urandom, $urandom});
    pend.push_back(model(c, mf, d, s));
    pm.push_back(d1[0] && d1[3] && link_mode[0] == 3'b001 ? 8'hFC : 8'hFF);
    sent++;
  endtask

  task automatic print_verdict;
    $display("checks %0d failures %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial
  begin
    #200_000;
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end

  initial
  begin
    {srst, reg_cs, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 21'h0};
    link_mode = {4{3'b100}};
    rx_in = '0;
    {fail_count, num_checks, sent} = 0;
    foreach (mw[k])
      mw[k] = 0;
    void'($urandom(32'hbc9a));
    repeat (10) @(negedge sys_clk);
    srst = 1'b0;
    for (int l = 0; l < 4; l++)
      foreach (offs[k])
      begin
        rd({2'(l), offs[k]}, v);
        chk(v, 8'h00, "reset value");
        rv[l * 3 + k] = 8'($urandom);
        wr({2'(l), offs[k]}, rv[l * 3 + k]);
      end
    for (int l = 0; l < 4; l++)
      foreach (offs[k])
      begin
        rd({2'(l), offs[k]}, v);
        chk(v, rv[l * 3 + k], "link copy");
      end
    wr(10'h010, 8'hFF);
    rd(10'h010, v);
    chk(v, 8'h00, "unmapped");
    rd(10'h0CE, v);
    chk(v, 8'h00, "control read");
    $display("direct registers done");
    foreach (idx[k])
    begin
      rv[k] = 8'($urandom);
      iw(2'h1, idx[k], rv[k], 1'b0);
    end
    foreach (idx[k])
    begin
      iw(2'h1, idx[k], 8'h00, 1'b1);
      rd(10'h1CF, v);
      chk(v, rv[k], "indirect readback");
    end
    $display("indirect registers done");
    for (int c = 1; c < 9; c++)
    begin
      iw(2'h0, 7'(c), {2'b00, 3'($urandom), 1'b0, 2'(c)}, 1'b0);
      iw(2'h0, 7'(c + 32), 8'($urandom), 1'b0);
      iw(2'h0, 7'(c + 64), {3'b000, 1'(c), 4'($urandom)}, 1'b0);
    end
    for (int p = 0; p < 7; p++)
    begin
      link_mode[0] = ph_mode[p];
      d0 = ph_d0[p];
      d1 = ph_d1[p];
      wr(10'h0D0, d0);
      wr(10'h0D1, d1);
      for (int f = 0; f < 5; f++)
        for (int c = 1; c < 9; c++)
          send(5'(c), f == 0 || f == 3);
      @(negedge sys_clk);
      check_out();
      rx_in[0].valid = 1'b0;
      $display("stream phase %0d done", p);
    end
    @(negedge sys_clk);
    chk(seen, sent, "bytes delivered");
    print_verdict();
  end
endmodule

`default_nettype wire
